// ### gpi_pin_irq.sv
// General-purpose pin configuration and interrupt status with APB access
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "gpi_regs.svh"

module gpi_pin_irq
  import gpi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire gpi_ev_s events,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  output logic pullup_enable,
  output logic pulldown_enable,
  output logic chip_select_input_n,
  output logic irq
);

  gpi_state_s r;
  gpi_state_s next_r;

  logic [9:0] idx;
  logic hit;
  logic wr;
  logic [4:0] raw;
  logic [4:0] den;
  logic [15:0] cond;
  logic [15:0] rise2;
  logic [15:0] clr1;
  logic [15:0] clr2;
  logic level;
  logic pin_rise;
  logic any_irq;
  logic fn_val;
  logic drive;
  logic [15:0] pin_rd;

  assign idx = paddr[11:2];
  assign hit = (paddr[1:0] == 2'h0) &&
               (idx == `GPI_PIN_IDX || idx == `GPI_ST1_IDX ||
                idx == `GPI_ST2_IDX || idx == `GPI_MSK1_IDX ||
                idx == `GPI_MSK2_IDX || idx == `GPI_CTRL_IDX ||
                idx == `GPI_DBC_IDX);
  assign wr = psel && penable && pwrite && hit;

  // Debounce lanes: pin, overtemp, second PLL, third PLL, FLL
  assign raw = {events.freq_loop_lock, events.third_pll_lock,
                events.second_pll_lock, events.overtemp, pin_in};
  assign den = {r.dbc[5], r.dbc[3], r.dbc[2], r.dbc[0],
                r.pin_cfg[`GPI_DB]};

  assign level = r.filt[0] ^ r.pin_cfg[`GPI_INV];

  // Bits 4 and 1 have no source and stay zero
  assign cond = {events.mic_short, events.mic_detect,
                 events.fifo_error, events.level_lock,
                 events.level_threshold, events.level_saturation,
                 events.peak_overload, events.noise_gate,
                 events.sequencer_done, events.dynamics_activity,
                 r.filt[4], 1'b0, r.filt[3], r.filt[2],
                 1'b0, r.filt[1]};
  assign rise2 = cond & ~r.src_q & `GPI_ST2_MASK;
  assign pin_rise = level && !r.pin_q && r.pin_cfg[`GPI_DIR];

  assign clr1 = (wr && idx == `GPI_ST1_IDX) ? pwdata[15:0] : 16'h0000;
  assign clr2 = (wr && idx == `GPI_ST2_IDX) ? pwdata[15:0] : 16'h0000;

  assign any_irq = |(r.st1 & ~r.mask1) || |(r.st2 & ~r.mask2);
  assign drive = !r.pin_cfg[`GPI_DIR];

  // Output level is unreliable as readback, so zero is returned
  assign pin_rd = {r.pin_cfg[15:7],
                   r.pin_cfg[`GPI_DIR] & level,
                   r.pin_cfg[5:0]};

  always_comb
  begin
    case (gpi_fn_e'(r.pin_cfg[`GPI_FN_MSB:0]))
      GPI_FN_LEVEL: fn_val = r.pin_cfg[`GPI_LVL];
      GPI_FN_IRQ: fn_val = r.irq;
      GPI_FN_OVERTEMP: fn_val = events.overtemp;
      GPI_FN_PLL2: fn_val = events.second_pll_lock;
      GPI_FN_PLL3: fn_val = events.third_pll_lock;
      GPI_FN_FLL: fn_val = events.freq_loop_lock;
      GPI_FN_DYN: fn_val = events.dynamics_activity;
      GPI_FN_SEQ: fn_val = events.sequencer_done;
      GPI_FN_NGATE: fn_val = events.noise_gate;
      GPI_FN_PEAK: fn_val = events.peak_overload;
      GPI_FN_SAT: fn_val = events.level_saturation;
      GPI_FN_THR: fn_val = events.level_threshold;
      GPI_FN_LOCK: fn_val = events.level_lock;
      GPI_FN_FIFO: fn_val = events.fifo_error;
      GPI_FN_OPERATING_CLOCK_OUT: fn_val = events.operating_clock_out;
      GPI_FN_DMCLK: fn_val = events.dmic_clock;
      GPI_FN_DMDAT: fn_val = events.dmic_data;
      GPI_FN_MICDET: fn_val = events.mic_detect;
      GPI_FN_MICSHORT: fn_val = events.mic_short;
      default: fn_val = 1'b0;
    endcase
  end

  always_comb
  begin
    next_r = r;
    for (int i = 0; i < `GPI_DB_LANES; i++)
    begin
      // A change must hold for several cycles before it is believed
      if (!den[i] || raw[i] == r.filt[i])
      begin
        next_r.filt[i] = raw[i];
        next_r.cnt[i] = 3'h0;
      end
      else if (r.cnt[i] == `GPI_DB_LAST)
      begin
        next_r.filt[i] = raw[i];
        next_r.cnt[i] = 3'h0;
      end
      else
      begin
        next_r.cnt[i] = r.cnt[i] + 3'h1;
      end
    end

    next_r.src_q = cond;
    next_r.pin_q = level;
    next_r.st1 = ((r.st1 & ~clr1) |
                  {10'h000, pin_rise, events.pin5_event, 4'h0}) &
                 `GPI_ST1_MASK;
    next_r.st2 = ((r.st2 & ~clr2) | rise2) & `GPI_ST2_MASK;

    if (wr)
    begin
      case (idx)
        `GPI_PIN_IDX:
          next_r.pin_cfg = pwdata[15:0] & `GPI_PIN_WMASK;
        `GPI_MSK1_IDX:
          next_r.mask1 = pwdata[15:0] & `GPI_ST1_MASK;
        `GPI_MSK2_IDX:
          next_r.mask2 = pwdata[15:0] | `GPI_MSK2_FIXED;
        `GPI_CTRL_IDX:
          next_r.irq_pol = pwdata[0];
        `GPI_DBC_IDX:
          next_r.dbc = (pwdata[15:0] & `GPI_DBC_WMASK) |
                       (`GPI_DBC_RST & ~`GPI_DBC_WMASK);
        default:
          next_r.err = r.err;
      endcase
    end

    // Read data is caught in the setup cycle so the bus sees a flop
    if (psel && !penable)
    begin
      next_r.err = !hit;
      case (idx)
        `GPI_PIN_IDX: next_r.rdata = {16'h0000, pin_rd};
        `GPI_ST1_IDX: next_r.rdata = {16'h0000, r.st1};
        `GPI_ST2_IDX: next_r.rdata = {16'h0000, r.st2};
        `GPI_MSK1_IDX: next_r.rdata = {16'h0000, r.mask1};
        `GPI_MSK2_IDX: next_r.rdata = {16'h0000, r.mask2};
        `GPI_CTRL_IDX: next_r.rdata = {31'h0, r.irq_pol};
        `GPI_DBC_IDX: next_r.rdata = {16'h0000, r.dbc};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end

    next_r.irq = any_irq ^ r.irq_pol;
    next_r.cs_n = (r.pin_cfg[`GPI_FN_MSB:0] == GPI_FN_CS_IN) ?
                  level : 1'b1;

    // Open drain only ever pulls low; a high level releases the pin
    if (r.pin_cfg[`GPI_OD])
    begin
      next_r.pin_out = 1'b0;
      next_r.pin_oe_n = !(drive && !(fn_val ^ r.pin_cfg[`GPI_INV]));
    end
    else
    begin
      next_r.pin_out = fn_val ^ r.pin_cfg[`GPI_INV];
      next_r.pin_oe_n = !drive;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.pin_cfg <= `GPI_PIN_RST;
      r.mask1 <= `GPI_MSK1_RST;
      r.mask2 <= `GPI_MSK2_RST;
      r.dbc <= `GPI_DBC_RST;
      r.pin_oe_n <= 1'b1;
      r.cs_n <= 1'b1;
      // Pin lane starts at the idle-high deselect level: no false edge
      r.filt <= 5'h01;
      r.pin_q <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign prdata = r.rdata;
  assign pready = psel && penable;
  assign pslverr = psel && penable && r.err;
  assign pin_out = r.pin_out;
  assign pin_oe_n = r.pin_oe_n;
  assign pullup_enable = r.pin_cfg[`GPI_PU];
  assign pulldown_enable = r.pin_cfg[`GPI_PD];
  assign chip_select_input_n = r.cs_n;
  assign irq = r.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_INPUT_RELEASES: assert property (
    r.pin_cfg[`GPI_DIR] |=> pin_oe_n)
    else $error("pin driven while configured as input");

  AST_FIXED_LEVEL: assert property (
    (r.pin_cfg[`GPI_FN_MSB:0] == GPI_FN_LEVEL && drive &&
     !r.pin_cfg[`GPI_OD]) |=>
    (!pin_oe_n && pin_out ==
     ($past(r.pin_cfg[`GPI_LVL]) ^ $past(r.pin_cfg[`GPI_INV]))))
    else $error("fixed level not driven on pin");

  AST_OPEN_DRAIN: assert property (
    (r.pin_cfg[`GPI_OD]) |=> (pin_out == 1'b0))
    else $error("open drain pin driven high");

  AST_READ_LEVEL: assert property (
    (psel && !penable && !pwrite && idx == `GPI_PIN_IDX &&
     r.pin_cfg[`GPI_DIR] && paddr[1:0] == 2'h0) |=>
    (prdata[`GPI_LVL] == $past(level)))
    else $error("pin level readback wrong");

  AST_SET_WINS: assert property (
    (rise2 != 16'h0000) |=> ((r.st2 & $past(rise2)) == $past(rise2)))
    else $error("status event lost");

  AST_STICKY: assert property (
    (clr2 == 16'h0000) |=> ((r.st2 & $past(r.st2)) == $past(r.st2)))
    else $error("status bit cleared without a write");

  AST_W1C_CLEARS: assert property (
    (clr2 != 16'h0000 && (rise2 & clr2) == 16'h0000) |=>
    ((r.st2 & $past(clr2)) == 16'h0000))
    else $error("write of one did not clear status");

  AST_EMPTY_BITS: assert property (
    r.st2[4] == 1'b0 && r.st2[1] == 1'b0 && r.st1[3:0] == 4'h0)
    else $error("status bit without event set");

  AST_IRQ_OUT: assert property (
    ##1 (irq == ($past(any_irq) ^ $past(r.irq_pol))))
    else $error("interrupt output disagrees with status");

  AST_MASKED_QUIET: assert property (
    (r.mask1 == `GPI_ST1_MASK && r.mask2 == `GPI_MSK2_RST &&
     !r.irq_pol) |=> (irq == 1'b0))
    else $error("masked event raised interrupt");

  AST_ST1_STICKY: assert property (
    (clr1 == 16'h0000) |=> ((r.st1 & $past(r.st1)) == $past(r.st1)))
    else $error("first status bit cleared without a write");

  AST_ST1_CLEARS: assert property (
    (clr1[5] && !pin_rise) |=> !r.st1[5])
    else $error("pin event status not cleared by write");

  AST_PIN_EVENT: assert property (
    pin_rise |=> r.st1[5])
    else $error("pin event not latched");

  AST_DEBOUNCE_HOLD: assert property (
    (den[1] && raw[1] != r.filt[1] && r.cnt[1] != `GPI_DB_LAST) |=>
    (r.filt[1] == $past(r.filt[1])))
    else $error("debounced source changed too early");

  AST_DEBOUNCE_BYPASS: assert property (
    !den[1] |=> (r.filt[1] == $past(raw[1])))
    else $error("undebounced source not passed through");

  AST_CS_IDLE: assert property (
    (r.pin_cfg[`GPI_FN_MSB:0] != GPI_FN_CS_IN) |=> chip_select_input_n)
    else $error("chip select asserted under another function");

  AST_RESERVED_LOW: assert property (
    (r.pin_cfg[`GPI_FN_MSB:0] > GPI_FN_MICSHORT && drive &&
     !r.pin_cfg[`GPI_OD]) |=> (pin_out == $past(r.pin_cfg[`GPI_INV])))
    else $error("reserved function drove the pin");

  AST_BAD_ADDR_ERR: assert property (
    (psel && !penable && !hit) ##1 (psel && penable) |-> pslverr)
    else $error("unmapped access not flagged");

  COV_PIN_EVENT: cover property (pin_rise ##1 r.st1[5]);
  COV_IRQ_RAISE: cover property (!any_irq ##1 any_irq ##1 irq);
  COV_CLEAR_RACE: cover property ((rise2 & clr2) != 16'h0000);
  COV_DEBOUNCED: cover property (r.cnt[1] == `GPI_DB_LAST);
  COV_DB_BYPASS: cover property (!den[1] && raw[1] && !r.filt[1]);

endmodule

`default_nettype wire

// ### gpi_pin_irq_bench.sv
// Self-checking bench for the pin and interrupt status block
`timescale 1ns/1ps
`default_nettype none
`include "gpi_regs.svh"

module gpi_pin_irq_bench
  import gpi_pkg::*;
;
  localparam logic [11:0] PIN = {`GPI_PIN_IDX, 2'h0};
  localparam logic [11:0] ST1 = {`GPI_ST1_IDX, 2'h0};
  localparam logic [11:0] ST2 = {`GPI_ST2_IDX, 2'h0};
  localparam logic [11:0] M2 = {`GPI_MSK2_IDX, 2'h0};
  localparam logic [11:0] CTL = {`GPI_CTRL_IDX, 2'h0};
  localparam logic [11:0] M1 = {`GPI_MSK1_IDX, 2'h0};
  localparam logic [11:0] DBC = {`GPI_DBC_IDX, 2'h0};
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, pin_in, pin_out, pin_oe_n, pu, pd, cs_n, irq;
  // Pin idles high, as a deselected chip-select line would
  logic ext_lvl = 1'h1;
  logic ext_en = 1'h1;
  gpi_ev_s ev = '0;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [4:0] fc [17] = '{5'h04, 5'h06, 5'h07, 5'h09, 5'h0a, 5'h0b,
    5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14,
    5'h15, 5'h16};
  int fb [17] = '{4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 3, 2, 1, 16, 17};
  logic [4:0] rs [4] = '{5'h02, 5'h05, 5'h08, 5'h17};

  always #50 pclk = ~pclk;

  gpi_pin_irq u_gpi_pin_irq (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(ev),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_enable(pu), .pulldown_enable(pd),
    .chip_select_input_n(cs_n), .irq(irq));

  gpi_pin_model u_gpi_pin_model (.pclk(pclk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pullup_enable(pu), .pulldown_enable(pd),
    .ext_en(ext_en), .ext_lvl(ext_lvl), .pin_in(pin_in));

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for the slave
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a,
    input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end

  initial
  begin
    wt(5);
    presetn <= 1'h1;
    chk("oe_n", 1, pin_oe_n);
    chk("irq", 0, irq);
    rdc("pin", PIN, 32'h8140);
    rdc("st2", ST2, 0);
    rdc("mask2", M2, 32'hffff);
    chk("cs_n idle", 1, cs_n);
    ev.overtemp <= 1'h1;
    wt(2);
    ev.overtemp <= 1'h0;
    wt(10);
    rdc("st2", ST2, 0);
    $display("test reset done");
    wr(PIN, 32'h6000);
    wt(2);
    chk("pu", 1, pu);
    chk("pd", 1, pd);
    wr(PIN, 32'h0041);
    wt(2);
    chk("oe_n", 0, pin_oe_n);
    chk("pin", 1, pin_out);
    wr(PIN, 32'h0441);
    wt(2);
    chk("pin", 0, pin_out);
    wr(PIN, 32'h0241);
    wt(2);
    chk("oe_n", 1, pin_oe_n);
    $display("test output done");
    for (int i = 0; i < 17; i++)
    begin
      wr(PIN, {27'h0, fc[i]});
      ev[fb[i]] <= 1'h1;
      wt(8);
      chk("fn hi", 1, pin_out);
      ev[fb[i]] <= 1'h0;
      wt(8);
      chk("fn lo", 0, pin_out);
    end
    ev.pin5_event <= 1'h1;
    wt(1);
    ev <= 18'h3ffff;
    foreach (rs[i])
    begin
      wr(PIN, {27'h0, rs[i]});
      wt(3);
      chk("reserved", 0, pin_out);
    end
    ev <= '0;
    chk("irq masked", 0, irq);
    rdc("st2", ST2, 32'hffed);
    rdc("st1", ST1, 32'h0010);
    wr(ST2, 0);
    rdc("st2", ST2, 32'hffed);
    wr(ST2, 32'hffff);
    wr(ST1, 32'hffff);
    rdc("st2", ST2, 0);
    rdc("st1", ST1, 0);
    $display("test functions done");
    wr(M2, 32'hfffe);
    ev.overtemp <= 1'h1;
    wt(8);
    chk("irq", 1, irq);
    wr(PIN, 32'h0003);
    wt(2);
    chk("pin irq", 1, pin_out);
    wr(CTL, 1);
    wt(2);
    chk("irq low", 0, irq);
    wr(CTL, 0);
    wr(ST2, 1);
    wt(2);
    chk("irq", 0, irq);
    rdc("st2", ST2, 0);
    ev <= '0;
    wr(DBC, 0);
    rdc("dbc", DBC, 32'h0012);
    ev.overtemp <= 1'h1;
    wt(1);
    ev.overtemp <= 1'h0;
    wt(3);
    rdc("st2 no debounce", ST2, 1);
    wr(ST2, 1);
    $display("test irq done");
    ext_lvl <= 1'h0;
    wr(PIN, 32'h8100); // Level only read back as input
    wt(8);
    chk("cs_n", 0, cs_n);
    ext_lvl <= 1'h1;
    wt(8);
    chk("cs_n", 1, cs_n);
    rdc("pin", PIN, 32'h8140);
    rdc("st1", ST1, 32'h0020);
    wr(PIN, 32'h8500);
    wt(8);
    chk("cs_n inv", 0, cs_n);
    wr(PIN, 32'ha000);
    ext_en <= 1'h0;
    rdc("pin pulldown", PIN, 32'ha000);
    chk("pu", 0, pu);
    wr(PIN, 32'hc000);
    rdc("pin pullup", PIN, 32'hc040);
    chk("pd", 0, pd);
    ext_en <= 1'h1;
    wr(M1, 32'h0010);
    wt(2);
    chk("irq pin", 1, irq);
    wr(ST1, 32'h0020);
    wt(2);
    chk("irq pin", 0, irq);
    presetn <= 1'h0;
    wt(2);
    presetn <= 1'h1;
    rdc("pin rst", PIN, 32'h8140);
    rdc("st1 rst", ST1, 0);
    chk("irq rst", 0, irq);
    xfer(1'h0, 12'hffc, 0);
    chk("err", 1, err);
    chk("rdata", 0, rd);
    $display("test input done");
    finish_test();
  end
endmodule

`default_nettype wire

// ### gpi_pin_model.sv
// Model of the external circuit hanging on the general-purpose pin
`timescale 1ns/1ps
`default_nettype none

module gpi_pin_model
(
  input wire logic pclk,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  input wire logic pullup_enable,
  input wire logic pulldown_enable,
  input wire logic ext_en,
  input wire logic ext_lvl,
  output logic pin_in
);
  logic last = 1'h0;

  always_comb
  begin
    if (!pin_oe_n)
      pin_in = pin_out;
    else if (ext_en)
      pin_in = ext_lvl;
    else if (pullup_enable)
      pin_in = 1'h1;
    else if (pulldown_enable)
      pin_in = 1'h0;
    else
      pin_in = ~last; // Floating: never let the old level linger
  end

  always @(posedge pclk)
    last <= pin_in;
endmodule

`default_nettype wire

// ### gpi_pkg.sv
// Types shared by the pin and interrupt status block
package gpi_pkg;

  typedef enum logic [4:0] {
    GPI_FN_CS_IN = 5'h00,
    GPI_FN_LEVEL = 5'h01,
    GPI_FN_IRQ = 5'h03,
    GPI_FN_OVERTEMP = 5'h04,
    GPI_FN_PLL2 = 5'h06,
    GPI_FN_PLL3 = 5'h07,
    GPI_FN_FLL = 5'h09,
    GPI_FN_DYN = 5'h0a,
    GPI_FN_SEQ = 5'h0b,
    GPI_FN_NGATE = 5'h0c,
    GPI_FN_PEAK = 5'h0d,
    GPI_FN_SAT = 5'h0e,
    GPI_FN_THR = 5'h0f,
    GPI_FN_LOCK = 5'h10,
    GPI_FN_FIFO = 5'h11,
    GPI_FN_OPERATING_CLOCK_OUT = 5'h12,
    GPI_FN_DMCLK = 5'h13,
    GPI_FN_DMDAT = 5'h14,
    GPI_FN_MICDET = 5'h15,
    GPI_FN_MICSHORT = 5'h16
  } gpi_fn_e;

  typedef struct packed {
    logic mic_short;
    logic mic_detect;
    logic fifo_error;
    logic level_lock;
    logic level_threshold;
    logic level_saturation;
    logic peak_overload;
    logic noise_gate;
    logic sequencer_done;
    logic dynamics_activity;
    logic freq_loop_lock;
    logic third_pll_lock;
    logic second_pll_lock;
    logic overtemp;
    logic operating_clock_out;
    logic dmic_clock;
    logic dmic_data;
    logic pin5_event;
  } gpi_ev_s;

  typedef struct packed {
    logic [15:0] pin_cfg;
    logic [15:0] st1;
    logic [15:0] st2;
    logic [15:0] mask1;
    logic [15:0] mask2;
    logic [15:0] dbc;
    logic irq_pol;
    logic [15:0] src_q;
    logic pin_q;
    logic [4:0] filt;
    logic [4:0][2:0] cnt;
    logic [31:0] rdata;
    logic err;
    logic pin_out;
    logic pin_oe_n;
    logic irq;
    logic cs_n;
  } gpi_state_s;

endpackage

// ### gpi_regs.svh
// Register indices, field positions, reset values and counts for gpi
`ifndef GPI_REGS_SVH
`define GPI_REGS_SVH

`define GPI_PIN_IDX 10'h205
`define GPI_ST1_IDX 10'h230
`define GPI_ST2_IDX 10'h231
`define GPI_MSK1_IDX 10'h238
`define GPI_MSK2_IDX 10'h239
`define GPI_CTRL_IDX 10'h240
`define GPI_DBC_IDX 10'h248

`define GPI_DIR 15
`define GPI_PU 14
`define GPI_PD 13
`define GPI_INV 10
`define GPI_OD 9
`define GPI_DB 8
`define GPI_LVL 6
`define GPI_FN_MSB 4

`define GPI_PIN_RST 16'h8100
`define GPI_PIN_WMASK 16'he75f
`define GPI_ST1_MASK 16'h0030
`define GPI_ST2_MASK 16'hffed
`define GPI_MSK1_RST 16'h0030
`define GPI_MSK2_RST 16'hffff
`define GPI_MSK2_FIXED 16'h0012
`define GPI_DBC_RST 16'h003f
`define GPI_DBC_WMASK 16'h002d

`define GPI_DB_LANES 5
`define GPI_DB_LAST 3'h3

`endif
